// ==== src/crs_core_support.v ====
// register file, stack pointer and interrupt dispatch of the core
`timescale 1ns/1ps
`include "crs_defs.vh"
module crs_core_support #(
  parameter NSRC = `CRS_NSRC,
  parameter [NSRC-1:0] LEVEL_MASK = {NSRC{1'b0}},
  parameter [15:0] SRAM_TOP = `CRS_SRAM_TOP,
  parameter [15:0] BOOT_START = `CRS_BOOT_START
)
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [4:0] ra_i,
  input wire [4:0] rb_i,
  output reg [7:0] ra_o,
  output reg [7:0] rb_o,
  output reg [15:0] rw_o,
  input wire we_i,
  input wire wwide_i,
  input wire [4:0] wa_i,
  input wire [15:0] wd_i,
  input wire [15:0] ds_addr_i,
  input wire ds_rd_i,
  input wire ds_wr_i,
  input wire [7:0] ds_wdata_i,
  output reg [7:0] ds_rdata_o,
  output reg ds_hit_o,
  input wire ptr_go_i,
  input wire [1:0] ptr_sel_i,
  input wire [1:0] ptr_mode_i,
  input wire [5:0] ptr_disp_i,
  output reg [15:0] ptr_addr_o,
  input wire [2:0] sp_op_i,
  output reg [15:0] sp_o,
  input wire alu_we_i,
  input wire [6:0] alu_flags_i,
  input wire sei_i,
  input wire cli_i,
  input wire return_from_interrupt_i,
  input wire insn_done_i,
  input wire sleep_i,
  input wire [15:0] pc_i,
  input wire vector_select_bit_i,
  input wire boot_reset_fuse_i,
  input wire boot_lock_pair_a_i,
  input wire boot_lock_pair_b_i,
  input wire [NSRC-1:0] irq_set_i,
  input wire [NSRC-1:0] irq_level_i,
  input wire [NSRC-1:0] irq_en_i,
  input wire [NSRC-1:0] irq_clr_i,
  output reg [NSRC-1:0] irq_flag_o,
  output reg [7:0] status_register_o,
  output reg irq_take_o,
  output reg [15:0] irq_vec_o,
  output reg irq_busy_o,
  output reg ret_done_o,
  output reg [15:0] rst_vec_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ENTRY = 2'h1;
  localparam ST_RET = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [15:0] sp_q;
  reg [15:0] sp_d;
  reg [7:0] status_register_q;
  reg [7:0] status_register_d;
  reg [NSRC-1:0] flag_q;
  reg hold_q;
  reg hold_d;

  wire [7:0] rf_ra;
  wire [7:0] rf_rb;
  wire [15:0] rf_rw;
  wire [7:0] rf_ds;
  wire [15:0] ptr_val;
  wire pick_valid;
  wire [7:0] pick_idx;

  function [15:0] section_base;
    input moved;
    begin
      section_base = moved ? BOOT_START : 16'h0000;
    end
  endfunction

  // data space decode: register file window and the I/O window
  wire ds_in_rf = (ds_addr_i <= `CRS_RF_TOP);
  wire ds_in_io = (ds_addr_i >= `CRS_IO_BASE) && (ds_addr_i <= `CRS_IO_TOP);
  wire [15:0] io_off = ds_addr_i - `CRS_IO_BASE;
  wire [5:0] io_a = io_off[5:0];
  wire io_spl = ds_in_io && (io_a == `CRS_IO_SPL);
  wire io_sph = ds_in_io && (io_a == `CRS_IO_SPH);
  wire io_status_register = ds_in_io && (io_a == `CRS_IO_STATUS_REGISTER);
  wire ds_wr_rf = ds_wr_i && ds_in_rf;

  // pointer address and writeback value
  reg [15:0] ptr_addr;
  reg [15:0] ptr_new;
  reg ptr_we;
  always @*
  begin
    ptr_addr = ptr_val;
    ptr_new = ptr_val;
    ptr_we = 1'b0;
    case (ptr_mode_i)
      `CRS_PM_DISP:
        ptr_addr = ptr_val + {10'h000, ptr_disp_i};
      `CRS_PM_POST_INC:
      begin
        ptr_new = ptr_val + 16'h0001;
        ptr_we = ptr_go_i;
      end
      `CRS_PM_PRE_DEC:
      begin
        ptr_addr = ptr_val - 16'h0001;
        ptr_new = ptr_val - 16'h0001;
        ptr_we = ptr_go_i;
      end
      default:
        ptr_addr = ptr_val;
    endcase
  end

  crs_regfile #(
    .NREG(`CRS_NREG)
  ) u_rf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ra_i(ra_i),
    .rb_i(rb_i),
    .ra_o(rf_ra),
    .rb_o(rf_rb),
    .rw_o(rf_rw),
    .we_i(we_i),
    .wwide_i(wwide_i),
    .wa_i(wa_i),
    .wd_i(wd_i),
    .ds_a_i(ds_addr_i[4:0]),
    .ds_we_i(ds_wr_rf),
    .ds_d_i(ds_wdata_i),
    .ds_q_o(rf_ds),
    .ptr_sel_i(ptr_sel_i),
    .ptr_we_i(ptr_we),
    .ptr_new_i(ptr_new),
    .ptr_val_o(ptr_val)
  );

  // flag sources remember, level sources pass straight through
  wire [NSRC-1:0] pend = (flag_q & ~LEVEL_MASK)
    | (irq_level_i & LEVEL_MASK);
  wire [NSRC-1:0] req = pend & irq_en_i;

  crs_prio #(
    .N(NSRC)
  ) u_prio (
    .req_i(req),
    .valid_o(pick_valid),
    .idx_o(pick_idx)
  );

  wire gie = status_register_q[`CRS_GIE_BIT];
  wire in_boot = (pc_i >= BOOT_START);
  wire lock_block = (boot_lock_pair_a_i && !in_boot)
    || (boot_lock_pair_b_i && in_boot);
  // sleeping core is at a boundary unless hold is set; hold keeps one instruction after return
  wire boundary = insn_done_i || (sleep_i && !hold_q);
  wire take = (state_q == ST_IDLE) && boundary && gie && !cli_i
    && !lock_block && pick_valid && !return_from_interrupt_i;
  wire [15:0] vec_off = ({8'h00, pick_idx} + 16'h0001) * `CRS_VEC_STEP;
  wire [NSRC-1:0] ack = take ? ({{(NSRC-1){1'b0}}, 1'b1} << pick_idx)
    : {NSRC{1'b0}};

  // dispatch sequencer, stack pointer and status register
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    sp_d = sp_q;
    status_register_d = status_register_q;
    if (insn_done_i)
      hold_d = 1'b0;
    if (sei_i)
      hold_d = 1'b1;
    case (sp_op_i)
      `CRS_SP_PUSH1: sp_d = sp_q - 16'h0001;
      `CRS_SP_PUSH2: sp_d = sp_q - 16'h0002;
      `CRS_SP_POP1: sp_d = sp_q + 16'h0001;
      `CRS_SP_POP2: sp_d = sp_q + 16'h0002;
      default: sp_d = sp_q;
    endcase
    if (alu_we_i)
      status_register_d[6:0] = alu_flags_i;
    if (ds_wr_i && io_status_register)
      status_register_d = ds_wdata_i;
    if (sei_i)
      status_register_d[`CRS_GIE_BIT] = 1'b1;
    if (cli_i)
      status_register_d[`CRS_GIE_BIT] = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (take)
        begin
          state_d = ST_ENTRY;
          cnt_d = sleep_i ? (`CRS_RESP_CYC + `CRS_WAKE_CYC)
            : `CRS_RESP_CYC;
          sp_d = sp_q - 16'h0002;
          status_register_d[`CRS_GIE_BIT] = 1'b0;
        end
        else if (return_from_interrupt_i)
        begin
          state_d = ST_RET;
          cnt_d = `CRS_RET_CYC;
          sp_d = sp_q + 16'h0002;
        end
      end
      ST_ENTRY, ST_RET:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          state_d = ST_IDLE;
          if (state_q == ST_RET)
          begin
            status_register_d[`CRS_GIE_BIT] = 1'b1;
            hold_d = 1'b1;
          end
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // byte writes from software land last, over any stack arithmetic
    if (ds_wr_i && io_spl)
      sp_d[7:0] = ds_wdata_i;
    if (ds_wr_i && io_sph)
      sp_d[15:8] = ds_wdata_i;
  end

  // data space read mux
  reg [7:0] ds_q;
  always @*
  begin
    ds_q = 8'h00;
    if (ds_in_rf)
      ds_q = rf_ds;
    else if (io_spl)
      ds_q = sp_q[7:0];
    else if (io_sph)
      ds_q = sp_q[15:8];
    else if (io_status_register)
      ds_q = status_register_q;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      sp_q <= SRAM_TOP;
      status_register_q <= `CRS_STATUS_REGISTER_RST;
      flag_q <= {NSRC{1'b0}};
      ra_o <= 8'h00;
      rb_o <= 8'h00;
      rw_o <= 16'h0000;
      ds_rdata_o <= 8'h00;
      ds_hit_o <= 1'b0;
      ptr_addr_o <= 16'h0000;
      sp_o <= SRAM_TOP;
      irq_flag_o <= {NSRC{1'b0}};
      status_register_o <= `CRS_STATUS_REGISTER_RST;
      irq_take_o <= 1'b0;
      irq_vec_o <= 16'h0000;
      irq_busy_o <= 1'b0;
      ret_done_o <= 1'b0;
      rst_vec_o <= 16'h0000;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      sp_q <= sp_d;
      status_register_q <= status_register_d;
      // a new event beats a clear in the same cycle
      flag_q <= (flag_q & ~irq_clr_i & ~ack) | irq_set_i;
      ra_o <= rf_ra;
      rb_o <= rf_rb;
      rw_o <= rf_rw;
      ds_rdata_o <= ds_rd_i ? ds_q : 8'h00;
      ds_hit_o <= (ds_rd_i || ds_wr_i) && (ds_in_rf || io_spl || io_sph
        || io_status_register);
      if (ptr_go_i)
        ptr_addr_o <= ptr_addr;
      sp_o <= sp_d;
      irq_flag_o <= (flag_q & ~irq_clr_i & ~ack) | irq_set_i;
      status_register_o <= status_register_d;
      irq_take_o <= take;
      if (take)
        irq_vec_o <= section_base(vector_select_bit_i) + vec_off;
      irq_busy_o <= (state_d != ST_IDLE);
      ret_done_o <= (state_q == ST_RET) && (cnt_q == 4'h1);
      rst_vec_o <= section_base(boot_reset_fuse_i);
    end
  end
endmodule

// ==== src/crs_defs.vh ====
// shared constants for the core register, stack and interrupt block
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH
`define CRS_NREG 32
`define CRS_NSRC 8
`define CRS_RF_TOP 16'h001f
`define CRS_IO_BASE 16'h0020
`define CRS_IO_TOP 16'h005f
`define CRS_IO_SPL 6'h3d
`define CRS_IO_SPH 6'h3e
`define CRS_IO_STATUS_REGISTER 6'h3f
`define CRS_PTR_LO_BASE 5'h1a
`define CRS_PTR_X 2'h0
`define CRS_PTR_Y 2'h1
`define CRS_PTR_Z 2'h2
`define CRS_PM_DISP 2'h0
`define CRS_PM_POST_INC 2'h1
`define CRS_PM_PRE_DEC 2'h2
`define CRS_SP_NONE 3'h0
`define CRS_SP_PUSH1 3'h1
`define CRS_SP_PUSH2 3'h2
`define CRS_SP_POP1 3'h3
`define CRS_SP_POP2 3'h4
`define CRS_GIE_BIT 7
`define CRS_STATUS_REGISTER_RST 8'h00
`define CRS_SRAM_TOP 16'h04ff
`define CRS_BOOT_START 16'h0c00
`define CRS_VEC_STEP 16'h0002
`define CRS_RESP_CYC 4'h4
`define CRS_WAKE_CYC 4'h4
`define CRS_RET_CYC 4'h4
`endif

// ==== src/crs_prio.v ====
// fixed priority pick, lowest index wins
`timescale 1ns/1ps
module crs_prio #(
  parameter N = 8
)
(
  input wire [N-1:0] req_i,
  output reg valid_o,
  output reg [7:0] idx_o
);
  integer i;

  // scan downward so the lowest set index is the last one kept
  always @*
  begin
    valid_o = 1'b0;
    idx_o = 8'h00;
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req_i[i])
      begin
        valid_o = 1'b1;
        idx_o = i[7:0];
      end
    end
  end
endmodule

// ==== src/crs_regfile.v ====
// working register file with pointer pair access
`timescale 1ns/1ps
`include "crs_defs.vh"
module crs_regfile #(
  parameter NREG = `CRS_NREG
)
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [4:0] ra_i,
  input wire [4:0] rb_i,
  output wire [7:0] ra_o,
  output wire [7:0] rb_o,
  output wire [15:0] rw_o,
  input wire we_i,
  input wire wwide_i,
  input wire [4:0] wa_i,
  input wire [15:0] wd_i,
  input wire [4:0] ds_a_i,
  input wire ds_we_i,
  input wire [7:0] ds_d_i,
  output wire [7:0] ds_q_o,
  input wire [1:0] ptr_sel_i,
  input wire ptr_we_i,
  input wire [15:0] ptr_new_i,
  output wire [15:0] ptr_val_o
);
  reg [7:0] rf_q [0:NREG-1];
  integer i;

  function [4:0] pair_lo;
    input [1:0] sel;
    begin
      pair_lo = `CRS_PTR_LO_BASE + {2'h0, sel, 1'b0};
    end
  endfunction

  wire [4:0] pl = pair_lo(ptr_sel_i);

  // two byte operands plus one word operand, all combinational
  assign ra_o = rf_q[ra_i];
  assign rb_o = rf_q[rb_i];
  assign rw_o = {rf_q[ra_i | 5'h01], rf_q[ra_i & 5'h1e]};
  assign ds_q_o = rf_q[ds_a_i];
  assign ptr_val_o = {rf_q[pl | 5'h01], rf_q[pl]};

  // alu result written last so it wins over a pointer writeback
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < NREG; i = i + 1)
        rf_q[i] <= 8'h00;
    end
    else if (ce_i)
    begin
      if (ptr_we_i)
      begin
        rf_q[pl] <= ptr_new_i[7:0];
        rf_q[pl | 5'h01] <= ptr_new_i[15:8];
      end
      if (ds_we_i)
        rf_q[ds_a_i] <= ds_d_i;
      if (we_i)
      begin
        if (wwide_i)
        begin
          rf_q[wa_i & 5'h1e] <= wd_i[7:0];
          rf_q[wa_i | 5'h01] <= wd_i[15:8];
        end
        else
          rf_q[wa_i] <= wd_i[7:0];
      end
    end
  end
endmodule

// ==== testbench/crs_core_support_chk.sv ====
// concurrent checks on the ports of the core support block
`timescale 1ns/1ps
module crs_chk #(
  parameter NSRC = 8
)
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [15:0] ds_addr_i,
  input wire ds_rd_i,
  input wire ds_wr_i,
  input wire [2:0] sp_op_i,
  input wire [15:0] sp_o,
  input wire sei_i,
  input wire cli_i,
  input wire return_from_interrupt_i,
  input wire sleep_i,
  input wire [NSRC-1:0] irq_set_i,
  input wire [NSRC-1:0] irq_clr_i,
  input wire [NSRC-1:0] irq_flag_o,
  input wire [7:0] status_register_o,
  input wire irq_take_o,
  input wire irq_busy_o,
  input wire ret_done_o,
  input wire ds_hit_o
);
  wire [15:0] dlt = sp_op_i == 3'h1 ? 16'hffff : sp_op_i == 3'h2 ? 16'hfffe :
    sp_op_i == 3'h3 ? 16'h0001 : sp_op_i == 3'h4 ? 16'h0002 : 16'h0000;
  wire hit_w = ds_addr_i < 16'h0020 ||
    (ds_addr_i > 16'h005c && ds_addr_i < 16'h0060);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // gie low keeps entry from moving sp in the same edge
  property p_sp_step;
    ce_i && !ds_wr_i && !return_from_interrupt_i && !irq_busy_o && !status_register_o[7]
      |=> sp_o == $past(sp_o) + $past(dlt);
  endproperty
  a_sp_step: assert property (p_sp_step)
    else $error("stack pointer step wrong");
  property p_take;
    irq_take_o |-> sp_o == $past(sp_o) - 16'h0002 &&
      !status_register_o[7] && $past(status_register_o[7]) && !$past(cli_i);
  endproperty
  a_take: assert property (p_take)
    else $error("interrupt entry wrong");
  property p_busy;
    irq_take_o && !$past(sleep_i) |-> irq_busy_o [*4] ##1 !irq_busy_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("entry length wrong");
  property p_wake;
    irq_take_o && $past(sleep_i) |-> irq_busy_o [*8] ##1 !irq_busy_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake entry length wrong");
  property p_ret;
    ce_i && return_from_interrupt_i && !irq_busy_o |=> sp_o == $past(sp_o) + 16'h0002
      ##[3:5] (ret_done_o && status_register_o[7]);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return sequence wrong");
  property p_gap;
    ret_done_o |=> !irq_take_o;
  endproperty
  a_gap: assert property (p_gap)
    else $error("take right after return");
  property p_cli;
    ce_i && cli_i |=> !irq_take_o && !status_register_o[7];
  endproperty
  a_cli: assert property (p_cli)
    else $error("take after global disable");
  property p_sei;
    ce_i && sei_i && !cli_i && !irq_busy_o && !status_register_o[7]
      |=> status_register_o[7] && !irq_take_o;
  endproperty
  a_sei: assert property (p_sei)
    else $error("global enable wrong");
  property p_set;
    ce_i && irq_set_i[1] |=> irq_flag_o[1];
  endproperty
  a_set: assert property (p_set)
    else $error("flag not raised");
  property p_clr;
    ce_i && irq_clr_i[6] && !irq_set_i[6] |=> !irq_flag_o[6];
  endproperty
  a_clr: assert property (p_clr)
    else $error("flag not cleared");
  property p_hit;
    ce_i && (ds_rd_i || ds_wr_i) |=> ds_hit_o == $past(hit_w);
  endproperty
  a_hit: assert property (p_hit)
    else $error("data space decode wrong");
endmodule

bind crs_core_support crs_chk #(.NSRC(NSRC)) u_chk (.*);

// ==== testbench/crs_core_support_tb.sv ====
// self-checking bench for the core support block
`timescale 1ns/1ps
module crs_core_support_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, we_i = 1'b0, wwide_i = 1'b0;
  logic ds_rd_i = 1'b0, ds_wr_i = 1'b0, ptr_go_i = 1'b0, alu_we_i = 1'b0;
  logic sei_i = 1'b0, cli_i = 1'b0, return_from_interrupt_i = 1'b0, sleep_i = 1'b0;
  logic vector_select_bit_i = 1'b0, boot_reset_fuse_i = 1'b0, slow = 1'b0;
  logic boot_lock_pair_a_i = 1'b0, boot_lock_pair_b_i = 1'b0;
  logic [4:0] ra_i = '0, rb_i = '0, wa_i = '0;
  logic [15:0] wd_i = '0, ds_addr_i = '0;
  logic [7:0] ds_wdata_i = '0, irq_set_i = '0, irq_level_i = '0;
  logic [7:0] irq_en_i = '0, irq_clr_i = '0;
  logic [1:0] ptr_sel_i = '0, ptr_mode_i = '0;
  logic [5:0] ptr_disp_i = '0;
  logic [2:0] sp_op_i = '0;
  logic [6:0] alu_flags_i = '0;
  wire insn_done_i, ds_hit_o, irq_take_o, irq_busy_o, ret_done_o;
  wire [15:0] pc_i, rw_o, ptr_addr_o, sp_o, irq_vec_o, rst_vec_o;
  wire [7:0] ra_o, rb_o, ds_rdata_o, irq_flag_o, status_register_o;
  int fail_count = 0, checks = 0, ntake = 0;

  crs_core_support #(.LEVEL_MASK(8'h01)) dut (.*);
  crs_pipe_model pipe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .slow_i(slow),
    .busy_i(irq_busy_o),
    .take_i(irq_take_o),
    .vec_i(irq_vec_o),
    .insn_done_o(insn_done_i),
    .pc_o(pc_i)
  );

  always #5 clk_i = ~clk_i;
  always @(negedge clk_i)
    if (irq_take_o === 1'b1)
      ntake++;

  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task dsw(input logic [15:0] a, input logic [7:0] d);
    ds_addr_i = a;
    ds_wdata_i = d;
    ds_wr_i = 1'b1;
    tick;
    ds_wr_i = 1'b0;
    tick;
  endtask
  task dsr(input logic [15:0] a, input logic [15:0] e);
    ds_addr_i = a;
    ds_rd_i = 1'b1;
    tick;
    ds_rd_i = 1'b0;
    chk("ds_rdata", ds_rdata_o, e);
  endtask
  // bounded wait for a take or for the end of a return
  task wt(input bit r);
    int n;
    n = 0;
    while ((r ? ret_done_o : irq_take_o) !== 1'b1 && n < 30)
    begin
      tick;
      n++;
    end
    chk("wait", n < 30, 1);
  endtask
  task pulse_sei;
    sei_i = 1'b1;
    tick;
    sei_i = 1'b0;
  endtask

  task t_sp;
    logic [15:0] e [1:4];
    e = '{16'h020f, 16'h020d, 16'h020e, 16'h0210};
    chk("sp", sp_o, 16'h04ff);
    chk("rst_vec", rst_vec_o, 0);
    dsr(16'h005e, 16'h0004);
    dsw(16'h005e, 8'h02);
    dsw(16'h005d, 8'h10);
    for (int i = 1; i < 5; i++)
    begin
      sp_op_i = i[2:0];
      tick;
      chk("sp", sp_o, e[i]);
    end
    ce_i = 1'b0;
    sp_op_i = 3'h1;
    repeat (2) tick;
    chk("sp", sp_o, 16'h0210);
    ce_i = 1'b1;
    sp_op_i = '0;
    alu_we_i = 1'b1;
    alu_flags_i = 7'h55;
    tick;
    alu_we_i = 1'b0;
    chk("status_register", status_register_o, 16'h0055);
    dsr(16'h0060, 16'h0000);
    chk("hit", ds_hit_o, 0);
  endtask

  task t_rf;
    we_i = 1'b1;
    wwide_i = 1'b1;
    wa_i = 5'h1a;
    wd_i = 16'h1234;
    tick;
    we_i = 1'b0;
    ra_i = 5'h1a;
    rb_i = 5'h1b;
    tick;
    chk("rw", rw_o, 16'h1234);
    chk("rb", rb_o, 16'h0012);
    chk("ra", ra_o, 16'h0034);
    dsr(16'h001a, 16'h0034);
    we_i = 1'b1;
    wwide_i = 1'b0;
    wd_i = 16'hff40;
    tick;
    we_i = 1'b0;
    ptr_go_i = 1'b1;
    ptr_mode_i = 2'h1;
    tick;
    chk("ptr", ptr_addr_o, 16'h1240);
    ptr_mode_i = 2'h2;
    tick;
    chk("ptr", ptr_addr_o, 16'h1240);
    ptr_mode_i = 2'h0;
    ptr_disp_i = 6'h3f;
    tick;
    ptr_go_i = 1'b0;
    chk("ptr", ptr_addr_o, 16'h127f);
    tick;
    chk("rw", rw_o, 16'h1240);
    we_i = 1'b1;
    wwide_i = 1'b1;
    wa_i = 5'h1e;
    wd_i = 16'habcd;
    tick;
    we_i = 1'b0;
    ptr_sel_i = 2'h2;
    ptr_disp_i = 6'h00;
    ptr_go_i = 1'b1;
    tick;
    ptr_go_i = 1'b0;
    chk("ptr", ptr_addr_o, 16'habcd);
  endtask

  task t_irq;
    irq_set_i = 8'h66;
    tick;
    irq_set_i = '0;
    irq_clr_i = 8'h40;
    tick;
    irq_clr_i = '0;
    chk("flag", irq_flag_o, 16'h0026);
    irq_en_i = 8'h24;
    dsw(16'h005f, 8'h2a);
    repeat (3) tick;
    chk("take", ntake, 0);
    pulse_sei;
    wt(0);
    chk("vec", irq_vec_o, 16'h0006);
    chk("status_register", status_register_o, 16'h002a);
    chk("flag", irq_flag_o, 16'h0022);
    slow = 1'b1;
    repeat (5) tick;
    return_from_interrupt_i = 1'b1;
    tick;
    return_from_interrupt_i = 1'b0;
    vector_select_bit_i = 1'b1;
    wt(1);
    chk("status_register", status_register_o, 16'h00aa);
    wt(0);
    chk("vec", irq_vec_o, 16'h0c0c);
    slow = 1'b0;
  endtask

  task t_lvl;
    int k;
    repeat (5) tick;
    irq_level_i = 8'h01;
    tick;
    irq_level_i = '0;
    irq_en_i = 8'h25;
    k = ntake;
    pulse_sei;
    boot_lock_pair_b_i = 1'b1;
    repeat (4) tick;
    chk("level", ntake, k);
    irq_level_i = 8'h01;
    repeat (4) tick;
    chk("lock", ntake, k);
    boot_lock_pair_b_i = 1'b0;
    wt(0);
    chk("vec", irq_vec_o, 16'h0c02);
    irq_level_i = '0;
    repeat (5) tick;
    irq_en_i = 8'h02;
    k = ntake;
    pulse_sei;
    cli_i = 1'b1;
    tick;
    cli_i = 1'b0;
    repeat (4) tick;
    chk("cli", ntake, k);
    pulse_sei;
    wt(0);
    chk("vec", irq_vec_o, 16'h0c04);
  endtask

  // a take while asleep must stretch entry by the wake cycles
  task t_slp;
    int n;
    repeat (5) tick;
    irq_en_i = 8'h02;
    irq_set_i = 8'h02;
    sleep_i = 1'b1;
    tick;
    irq_set_i = '0;
    pulse_sei;
    wt(0);
    sleep_i = 1'b0;
    n = 0;
    while (irq_busy_o === 1'b1 && n < 30)
    begin
      tick;
      n++;
    end
    chk("wake", n, 8);
  endtask

  task t_rst;
    boot_reset_fuse_i = 1'b1;
    rst_i = 1'b1;
    repeat (2) tick;
    rst_i = 1'b0;
    tick;
    chk("rst_vec", rst_vec_o, 16'h0c00);
    chk("sp", sp_o, 16'h04ff);
    chk("status_register", status_register_o, 0);
  endtask

  task results;
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) tick;
    rst_i = 1'b0;
    t_sp;
    t_rf;
    t_irq;
    t_lvl;
    t_slp;
    t_rst;
    results;
  end
  // the sequence needs well under two hundred cycles; the 5000-cycle limit is ample margin
  initial
  begin
    #50000;
    fail_count++;
    results;
  end
endmodule

// ==== testbench/crs_pipe_model.sv ====
// stand-in for the instruction pipeline beside the block
`timescale 1ns/1ps
module crs_pipe_model (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  input wire busy_i,
  input wire take_i,
  input wire [15:0] vec_i,
  output reg insn_done_o,
  output reg [15:0] pc_o
);
  reg ph_q;
  // slow mode stands for two-cycle instructions
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ph_q <= 1'b0;
      insn_done_o <= 1'b0;
      pc_o <= 16'h0000;
    end
    else if (take_i)
    begin
      insn_done_o <= 1'b0;
      pc_o <= vec_i;
    end
    else
    begin
      ph_q <= slow_i & ~ph_q;
      insn_done_o <= ~busy_i & ~(slow_i & ~ph_q);
      if (insn_done_o)
        pc_o <= pc_o + 16'h0001;
    end
  end
endmodule
